// File: common/pmx_params.svh
// Constants for the shared pad function selector: sizes, pad indices, legal masks
`ifndef PMX_PARAMS_SVH
`define PMX_PARAMS_SVH

// ****************************************
// Sizes
// ****************************************
`define PMX_NPAD 21
`define PMX_NFUNC 5
`define PMX_SEL_W 3
`define PMX_IDX_W 5
`define PMX_SEL_RESET 3'h0

// ****************************************
// Pad indices
// ****************************************
`define PMX_PAD_TWI_CLK 0
`define PMX_PAD_TWI_DATA 1
`define PMX_PAD_GP2 2
`define PMX_PAD_GP3 3
`define PMX_PAD_GP4 4
`define PMX_PAD_GP5 5
`define PMX_PAD_FL0_FIRST 6
`define PMX_PAD_FL0_LAST 9
`define PMX_PAD_FL1_FIRST 10
`define PMX_PAD_FL1_LAST 13
`define PMX_PAD_FL2_CLK 14
`define PMX_PAD_FL2_DOUT 15
`define PMX_PAD_FL2_DIN 16
`define PMX_PAD_FL2_CS 17
`define PMX_PAD_FL2_LAST 19
`define PMX_PAD_PWM1 20

// ****************************************
// Legal selection values per pad group, one bit per value
// ****************************************
`define PMX_MASK_TWI 5'h0f
`define PMX_MASK_GP23 5'h0f
`define PMX_MASK_GP45 5'h0b
`define PMX_MASK_FL01 5'h1f
`define PMX_MASK_FL2_OUT 5'h1b
`define PMX_MASK_FL2_OTHER 5'h1f
// Hold and write-protect pads of the third group stop at value two
`define PMX_MASK_FL2_CTRL 5'h07
`define PMX_MASK_PWM1 5'h1f

`endif

// File: common/pmx_pkg.sv
// Types shared by the shared pad function selector
package pmx_pkg;

   // Drive offered by one function to one pad
   typedef struct packed {
      logic drive;
      logic enable;
   } pmx_pad_drive_type;

   // Boot source, in strap code order
   typedef enum logic [1:0] {
      boot_spi_nor,
      boot_spi_nand,
      boot_managed_card,
      boot_serial_nand
   } pmx_boot_type;

endpackage

// File: hw/pmx_strap_latch.sv
// Strap capture at reset release: boot source and second radio die clock mode
`timescale 1ns/100ps
`include "pmx_params.svh"

module pmx_strap_latch (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [1:0] boot_strap,
   input wire logic uart_tx_strap,
   output pmx_pkg::pmx_boot_type boot_source,
   output logic second_die_buffer_mode,
   output logic strap_valid
);

   // ****************************************
   // Capture
   // ****************************************

   // Decode of the live strap levels
   wire pmx_pkg::pmx_boot_type next_boot_source = pmx_pkg::pmx_boot_type'(boot_strap);
   wire logic next_buffer_mode = uart_tx_strap;
   wire logic take = !strap_valid;

   // First edge after release takes the straps, then they are frozen
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         boot_source <= pmx_pkg::boot_spi_nor;
         second_die_buffer_mode <= 1'b0;
         strap_valid <= 1'b0;
      end
      else if (take)
      begin
         boot_source <= next_boot_source;
         second_die_buffer_mode <= next_buffer_mode;
         strap_valid <= 1'b1;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   boot_decode_a: assert property (take |=> boot_source == pmx_pkg::pmx_boot_type'($past(boot_strap)))
      else $error("boot source not taken from straps");
   clock_mode_a: assert property (take |=> second_die_buffer_mode == $past(uart_tx_strap))
      else $error("die clock mode not taken from strap");
   strap_hold_a: assert property (strap_valid |=> strap_valid && $stable(boot_source)
      && $stable(second_die_buffer_mode))
      else $error("strap values changed after capture");
   strap_cover_c: cover property (take ##1 boot_source == pmx_pkg::boot_serial_nand);

endmodule

// File: hw/pmx_pin_select.sv
// Shared pad function selector: per-pad selection registers, pad routing, strap capture
//
// Summary of operation
// - Each pad picks one of up to five functions
// - Two-wire pads: gpio, controller, serdes, usb3
// - First flash pads: gpio, nand, card, spi, uart
// - Second flash pads: gpio, spi, card, uarts
// - Third flash pads; value two not on clk/data-out
// - Second pwm pad: gpio, pwm, reset, offload uarts
// - Gpio pads two-five: vbus/pcie, wireless, uart; value two not on pads four/five
// - Boot strap decodes nor, nand, card, serial
// - Uart transmit strap picks crystal or buffer
`timescale 1ns/100ps
`include "pmx_params.svh"

module pmx_pin_select (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic sel_wr,
   input wire logic [`PMX_IDX_W-1:0] sel_pad,
   input wire logic [`PMX_SEL_W-1:0] sel_value,
   input wire logic [`PMX_IDX_W-1:0] sel_rd_pad,
   output logic [`PMX_SEL_W-1:0] sel_rd_value,
   output logic sel_reject,
   input wire logic [`PMX_NPAD-1:0] pad_in,
   output logic [`PMX_NPAD-1:0] pad_out,
   output logic [`PMX_NPAD-1:0] pad_oe,
   input wire pmx_pkg::pmx_pad_drive_type [`PMX_NPAD-1:0][`PMX_NFUNC-1:0] fn_drive,
   output logic [`PMX_NPAD-1:0][`PMX_NFUNC-1:0] fn_in,
   input wire logic [1:0] boot_strap,
   input wire logic uart_tx_strap,
   output pmx_pkg::pmx_boot_type boot_source,
   output logic second_die_buffer_mode,
   output logic strap_valid
);

   // ****************************************
   // Legal selections per pad
   // ****************************************

   // Returns the set of selection values that a pad offers
   function automatic logic [`PMX_NFUNC-1:0] pmx_legal_mask(input logic [`PMX_IDX_W-1:0] pad);
      logic [`PMX_NFUNC-1:0] mask;
      mask = '0;
      if (pad <= `PMX_IDX_W'(`PMX_PAD_TWI_DATA))
         mask = `PMX_MASK_TWI;
      else if (pad <= `PMX_IDX_W'(`PMX_PAD_GP3))
         mask = `PMX_MASK_GP23;
      else if (pad <= `PMX_IDX_W'(`PMX_PAD_GP5))
         mask = `PMX_MASK_GP45;
      else if (pad <= `PMX_IDX_W'(`PMX_PAD_FL0_LAST))
         mask = `PMX_MASK_FL01;
      else if (pad <= `PMX_IDX_W'(`PMX_PAD_FL1_LAST))
         mask = `PMX_MASK_FL01;
      else if (pad <= `PMX_IDX_W'(`PMX_PAD_FL2_DOUT))
         mask = `PMX_MASK_FL2_OUT;
      else if (pad <= `PMX_IDX_W'(`PMX_PAD_FL2_CS))
         mask = `PMX_MASK_FL2_OTHER;
      else if (pad <= `PMX_IDX_W'(`PMX_PAD_FL2_LAST))
         mask = `PMX_MASK_FL2_CTRL;
      else if (pad == `PMX_IDX_W'(`PMX_PAD_PWM1))
         mask = `PMX_MASK_PWM1;
      return mask;
   endfunction

   // ****************************************
   // Selection registers
   // ****************************************

   logic [`PMX_SEL_W-1:0] pad_sel [`PMX_NPAD];

   // Write check: pad must exist and offer the value
   wire logic [`PMX_NFUNC-1:0] wr_mask = pmx_legal_mask(sel_pad);
   wire logic wr_value_ok = sel_value < `PMX_SEL_W'(`PMX_NFUNC);
   wire logic wr_ok = wr_value_ok && wr_mask[sel_value[2:0] % `PMX_NFUNC];
   wire logic next_reject = sel_wr && !wr_ok;
   wire logic rd_pad_ok = sel_rd_pad < `PMX_IDX_W'(`PMX_NPAD);
   wire logic [`PMX_SEL_W-1:0] next_rd_value = rd_pad_ok ? pad_sel[sel_rd_pad] : `PMX_SEL_RESET;

   // Pads come out of reset in function zero
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         for (int p = 0; p < `PMX_NPAD; p++)
            pad_sel[p] <= `PMX_SEL_RESET;
      end
      else if (sel_wr && wr_ok)
      begin
         pad_sel[sel_pad] <= sel_value;
      end
   end

   // Readback and refusal flag
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sel_rd_value <= `PMX_SEL_RESET;
         sel_reject <= 1'b0;
      end
      else
      begin
         sel_rd_value <= next_rd_value;
         sel_reject <= next_reject;
      end
   end

   // ****************************************
   // Pad routing
   // ****************************************

   logic [`PMX_NPAD-1:0] next_out;
   logic [`PMX_NPAD-1:0] next_oe;
   logic [`PMX_NPAD-1:0][`PMX_NFUNC-1:0] next_fn_in;

   // Selected function owns pad drive; unselected ones see zero
   // With the chip-select pad in value zero, only the gpio line drives it
   for (genvar p = 0; p < `PMX_NPAD; p++)
   begin : g_pad
      assign next_out[p] = fn_drive[p][pad_sel[p] % `PMX_NFUNC].drive;
      assign next_oe[p] = fn_drive[p][pad_sel[p] % `PMX_NFUNC].enable;
      for (genvar f = 0; f < `PMX_NFUNC; f++)
      begin : g_fn
         assign next_fn_in[p][f] = pad_in[p] && (pad_sel[p] == `PMX_SEL_W'(f));
      end
   end

   // Registered pad and function outputs
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pad_out <= '0;
         pad_oe <= '0;
         fn_in <= '0;
      end
      else
      begin
         pad_out <= next_out;
         pad_oe <= next_oe;
         fn_in <= next_fn_in;
      end
   end

   // ****************************************
   // Strap capture
   // ****************************************

   // Boot source and die clock mode latched once after release
   pmx_strap_latch u_strap (
      .clk(clk),
      .sys_rst(sys_rst),
      .boot_strap(boot_strap),
      .uart_tx_strap(uart_tx_strap),
      .boot_source(boot_source),
      .second_die_buffer_mode(second_die_buffer_mode),
      .strap_valid(strap_valid)
   );

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sel_write_a: assert property (sel_wr && wr_ok |=> pad_sel[$past(sel_pad)] == $past(sel_value))
      else $error("legal selection write not stored");
   sel_refuse_a: assert property (sel_wr && !wr_ok |=> sel_reject)
      else $error("illegal selection not refused");
   twi_route_a: assert property (pad_sel[`PMX_PAD_TWI_CLK] == 3'h3
      |=> pad_oe[`PMX_PAD_TWI_CLK] == $past(fn_drive[`PMX_PAD_TWI_CLK][3].enable))
      else $error("two-wire pad not routed to usb3 management");
   fl0_route_a: assert property (pad_sel[`PMX_PAD_FL0_FIRST] == 3'h4
      |=> pad_out[`PMX_PAD_FL0_FIRST] == $past(fn_drive[`PMX_PAD_FL0_FIRST][4].drive))
      else $error("first flash pad not routed to uart");
   fl1_input_a: assert property (pad_sel[`PMX_PAD_FL1_FIRST] == 3'h2
      |=> fn_in[`PMX_PAD_FL1_FIRST][2] == $past(pad_in[`PMX_PAD_FL1_FIRST])
      && !fn_in[`PMX_PAD_FL1_FIRST][0])
      else $error("second flash pad input misrouted");
   fl2_clk_a: assert property (sel_wr && sel_pad == `PMX_IDX_W'(`PMX_PAD_FL2_CLK) && sel_value == 3'h2
      |=> sel_reject ##1 pad_sel[`PMX_PAD_FL2_CLK] != 3'h2)
      else $error("value two accepted on third flash clock pad");
   pwm1_route_a: assert property (pad_sel[`PMX_PAD_PWM1] == 3'h4
      |=> pad_out[`PMX_PAD_PWM1] == $past(fn_drive[`PMX_PAD_PWM1][4].drive))
      else $error("pwm pad not routed to offload uart");
   gp4_refuse_a: assert property (sel_wr && sel_pad == `PMX_IDX_W'(`PMX_PAD_GP4) && sel_value == 3'h2
      |=> sel_reject)
      else $error("value two accepted on gpio pad four");
   sel_legal_a: assert property (pad_sel[`PMX_PAD_FL2_DOUT] != 3'h2 && pad_sel[`PMX_PAD_FL2_DOUT] < 3'h5
      && pad_sel[`PMX_PAD_FL2_LAST] < 3'h3)
      else $error("pad holds an illegal selection");

   write_cover_c: cover property (sel_wr && wr_ok ##1 sel_rd_value != `PMX_SEL_RESET);
   refuse_cover_c: cover property (sel_wr && !wr_ok ##1 sel_reject);
   spi_cover_c: cover property (pad_sel[`PMX_PAD_FL2_CS] == 3'h4 ##1 pad_oe[`PMX_PAD_FL2_CS]);

endmodule

// File: tb/pmx_far_model.sv
// Far-side model: strap resistors, peripheral function drive and a gpio chip-select master
`timescale 1ns/100ps
`include "pmx_params.svh"

module pmx_far_model #(
   parameter int seed_init = 41993
) (
   input wire logic clk,
   input wire logic [2:0] strap_code,
   input wire logic cs_xfer,
   output logic [1:0] boot_strap,
   output logic uart_tx_strap,
   output logic [`PMX_NPAD-1:0] pad_in,
   output pmx_pkg::pmx_pad_drive_type [`PMX_NPAD-1:0][`PMX_NFUNC-1:0] fn_drive
);
   integer seed = seed_init;
   logic [223:0] r;
   pmx_pkg::pmx_pad_drive_type [`PMX_NPAD-1:0][`PMX_NFUNC-1:0] next_drive;

   // ****************************************
   // Board strap resistors
   // ****************************************
   assign boot_strap = strap_code[1:0];
   assign uart_tx_strap = strap_code[2];

   // New pad levels and function drive after each falling edge
   always
   begin
      for (int i = 0; i < 7; i++)
      begin
         r = {r[191:0], $random(seed)};
      end
      // Gpio chip-select line: low for a transfer, high otherwise
      next_drive = r[209:0];
      next_drive[`PMX_PAD_FL2_CS][0] = '{drive: ~cs_xfer, enable: 1'b1};
      pad_in <= r[220:200];
      fn_drive <= next_drive;
      @(negedge clk);
   end
endmodule

// File: tb/tb_shared_pin_function_select.sv
// Self-checking bench for the shared pad function selector
`timescale 1ns/100ps
`include "pmx_params.svh"

module tb_shared_pin_function_select;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic sel_wr = 1'b0;
   logic [`PMX_IDX_W-1:0] sel_pad = 5'h00;
   logic [`PMX_SEL_W-1:0] sel_value = 3'h0;
   logic [`PMX_IDX_W-1:0] sel_rd_pad = 5'h00;
   logic [2:0] strap_code = 3'h0;
   logic cs_xfer = 1'b0;
   logic [`PMX_SEL_W-1:0] sel_rd_value;
   logic sel_reject;
   logic [`PMX_NPAD-1:0] pad_in, pad_out, pad_oe;
   pmx_pkg::pmx_pad_drive_type [`PMX_NPAD-1:0][`PMX_NFUNC-1:0] fn_drive;
   logic [`PMX_NPAD-1:0][`PMX_NFUNC-1:0] fn_in;
   logic [1:0] boot_strap;
   logic uart_tx_strap;
   pmx_pkg::pmx_boot_type boot_source;
   logic second_die_buffer_mode;
   logic strap_valid;
   integer seed = 41993;
   logic [31:0] rnd;
   int n_fail = 0;
   int checked = 0;
   logic [2:0] model_sel [`PMX_NPAD];
   logic [`PMX_NPAD-1:0] exp_out, exp_oe;
   logic [`PMX_NPAD-1:0][`PMX_NFUNC-1:0] exp_in;
   logic exp_rej;
   logic [2:0] exp_rd;

   always #5 clk = ~clk;

   pmx_pin_select DUT (.clk(clk), .sys_rst(sys_rst), .sel_wr(sel_wr), .sel_pad(sel_pad),
      .sel_value(sel_value), .sel_rd_pad(sel_rd_pad), .sel_rd_value(sel_rd_value),
      .sel_reject(sel_reject), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
      .fn_drive(fn_drive), .fn_in(fn_in), .boot_strap(boot_strap), .uart_tx_strap(uart_tx_strap),
      .boot_source(boot_source), .second_die_buffer_mode(second_die_buffer_mode),
      .strap_valid(strap_valid));

   pmx_far_model far (.clk(clk), .strap_code(strap_code), .cs_xfer(cs_xfer), .boot_strap(boot_strap),
      .uart_tx_strap(uart_tx_strap), .pad_in(pad_in), .fn_drive(fn_drive));

   // ****************************************
   // Expectation functions and model
   // ****************************************
   // Selection values each pad accepts
   function automatic logic legal(input logic [4:0] p, input logic [2:0] v);
      logic [4:0] m;
      case (p)
         5'h00, 5'h01: m = 5'h0f;
         5'h02, 5'h03: m = 5'h0f;
         5'h04, 5'h05: m = 5'h0b;
         5'h0e, 5'h0f: m = 5'h1b;
         5'h12, 5'h13: m = 5'h07;
         default: m = (p > 5'h14) ? 5'h00 : 5'h1f;
      endcase
      return (v < 3'h5) && m[v];
   endfunction

   // Reference copy of the selections and registered routing
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         for (int p = 0; p < `PMX_NPAD; p++) model_sel[p] <= 3'h0;
         exp_out <= '0;
         exp_oe <= '0;
         exp_in <= '0;
         exp_rej <= 1'b0;
         exp_rd <= 3'h0;
      end
      else
      begin
         for (int p = 0; p < `PMX_NPAD; p++)
         begin
            exp_out[p] <= fn_drive[p][model_sel[p]].drive;
            exp_oe[p] <= fn_drive[p][model_sel[p]].enable;
            for (int f = 0; f < `PMX_NFUNC; f++) exp_in[p][f] <= (model_sel[p] == f) && pad_in[p];
         end
         exp_rej <= sel_wr && !legal(sel_pad, sel_value);
         exp_rd <= (sel_rd_pad > 5'h14) ? 3'h0 : model_sel[sel_rd_pad];
         if (sel_wr && legal(sel_pad, sel_value)) model_sel[sel_pad] <= sel_value;
      end
   end

   task automatic check(input string name, input logic [127:0] exp, input logic [127:0] got);
      checked++;
      if (exp !== got)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Selector outputs compared with the model at every falling edge outside reset
   always @(negedge clk)
   begin
      if (!sys_rst)
      begin
         check("pad_out", exp_out, pad_out);
         check("pad_oe", exp_oe, pad_oe);
         check("fn_in", exp_in, fn_in);
         check("sel_reject", exp_rej, sel_reject);
         check("sel_rd_value", exp_rd, sel_rd_value);
      end
   end

   // ****************************************
   // Scenarios
   // ****************************************
   // Reset with a strap code, then confirm capture and freeze
   task automatic strap_reset(input logic [2:0] code);
      sys_rst <= 1'b1;
      strap_code <= code;
      repeat (6) @(negedge clk);
      sys_rst <= 1'b0;
      @(negedge clk);
      check("boot_source", code[1:0], boot_source);
      check("buffer_mode", code[2], second_die_buffer_mode);
      check("strap_valid", 1'b1, strap_valid);
      strap_code <= ~code;
      repeat (3) @(negedge clk);
      check("strap_hold", {code[1:0], code[2], 1'b1}, {boot_source, second_die_buffer_mode, strap_valid});
   endtask

   task automatic wr(input logic [4:0] p, input logic [2:0] v);
      @(negedge clk);
      sel_wr <= 1'b1;
      sel_pad <= p;
      sel_value <= v;
      sel_rd_pad <= p;
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      for (int c = 0; c < 8; c++) strap_reset(c[2:0]);
      for (int p = 0; p < 32; p++)
         for (int v = 0; v < 8; v++) wr(p[4:0], v[2:0]);
      repeat (2000)
      begin
         @(negedge clk);
         rnd = $random(seed);
         sel_wr <= rnd[0];
         sel_pad <= rnd[8:4];
         sel_value <= rnd[14:12];
         sel_rd_pad <= rnd[20:16];
      end
      wr(5'h11, 3'h0);
      @(negedge clk);
      sel_wr <= 1'b0;
      cs_xfer <= 1'b1;
      repeat (3) @(negedge clk);
      check("cs_low", 2'h1, {pad_out[17], pad_oe[17]});
      cs_xfer <= 1'b0;
      repeat (3) @(negedge clk);
      check("cs_high", 2'h3, {pad_out[17], pad_oe[17]});
      strap_reset(3'h5);
      wrap_up;
   end

   // Watchdog against a hang
   initial
   begin
      #100000;
      n_fail++;
      wrap_up;
   end
endmodule
